/* File: core/fdl_loader.sv */
// flash descriptor loader: fetches bytes 0x000-0x2D9 of sector 0, checks them, runs init entries, programs access settings
`timescale 1ns/1ps
// Functional notes
// - no descriptor means single-bit SPI access
// - first 4KB is descriptor only, never code
// - firmware fetch starts at byte 0x1F84
// - valid only with signature A7 F1 A5 F1
// - erase size from bytes 0x05-0x06
// - write transactions limited by bytes 0x07-0x08
// - low-clock mode uses set at 0x09
// - high-clock mode uses set at 0x51
// - eighteen init entries at 0x99 to 0x2D8
// - flags bit0 picks half or full rate
// - bit2 clear boots despite errors
// - bit2 set plus fatal error blocks boot
// - chip and sector erase slots 0x00,0x10
// - read and write slots 0x20,0x30
// - init starts at index at 0x40
// - run exactly length-field init commands
// - switch settings after switchover index command
// - entry is command plus 16 payload bytes
// - command is two control, two instruction words
module fdl_loader
    import fdl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic high_clk_mode,
    input wire logic fatal_error,
    output logic rd_req,
    output logic [23:0] rd_addr,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    output logic init_req,
    output logic [127:0] init_cmd_ff,
    output logic [127:0] init_payload_ff,
    input wire logic init_done,
    input wire logic [1:0] cmd_sel,
    output logic [127:0] cmd_word_ff,
    output logic desc_valid_ff,
    output logic [2:0] access_prot_ff,
    output logic full_speed_ff,
    output logic init_high_clk_ff,
    output logic [15:0] erase_size_ff,
    output logic [15:0] write_size_ff,
    output logic [23:0] image_start_ff,
    output logic boot_en,
    output logic load_done_ff
);
    typedef enum logic [2:0] {FDL_IDLE, FDL_FETCH, FDL_CHECK, FDL_PARSE, FDL_INIT_LD, FDL_INIT_RUN, FDL_DONE} fdl_state_t;
    fdl_state_t state_ff;
    logic [9:0] fetch_ff;
    logic [9:0] rd_ptr_ff;
    logic [5:0] ld_cnt_ff;
    logic [15:0] init_idx_ff;
    logic [15:0] init_left_ff;
    logic [15:0] switch_idx_ff;
    logic [7:0] flags_ff;
    logic [31:0] sig_ff;
    logic switched_ff;
    logic [7:0] mem_q;
    logic [9:0] mem_raddr;
    logic [9:0] set_base;
    logic [6:0] parse_cnt_ff;
    logic [6:0] parse_ofs_ff;
    logic [9:0] sel_ofs;

    // set base depends on core clock mode in effect
    assign set_base = high_clk_mode ? FDL_OFS_SET_HIGH : FDL_OFS_SET_LOW;

    function automatic logic [6:0] fdl_slot(input logic [1:0] sel);
        case (sel)
            2'h0: fdl_slot = FDL_SET_CHIP_ERASE;
            2'h1: fdl_slot = FDL_SET_SECT_ERASE;
            2'h2: fdl_slot = FDL_SET_READ;
            default: fdl_slot = FDL_SET_WRITE;
        endcase
    endfunction : fdl_slot

    fdl_desc_mem #(.DEPTH(1024), .AW(10)) u_mem (
        .clk(clk),
        .wr_en(state_ff == FDL_FETCH && rd_valid),
        .wr_addr(fetch_ff),
        .wr_data(rd_data),
        .rd_addr(mem_raddr),
        .rd_data_ff(mem_q)
    );

    // only the descriptor bytes are fetched, well inside the reserved region
    assign rd_req = (state_ff == FDL_FETCH);
    assign rd_addr = {14'h0, fetch_ff};
    assign init_req = (state_ff == FDL_INIT_RUN);
    assign sel_ofs = set_base + {3'h0, parse_ofs_ff};
    assign mem_raddr = rd_ptr_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= FDL_IDLE;
        end else begin
            case (state_ff)
                FDL_IDLE: if (start) state_ff <= FDL_FETCH;
                FDL_FETCH: if (rd_valid && fetch_ff == FDL_DESC_LAST) state_ff <= FDL_CHECK;
                FDL_CHECK: begin
                    if (ld_cnt_ff == 6'h06) begin
                        state_ff <= (sig_ff == {FDL_SIG0, FDL_SIG1, FDL_SIG2, FDL_SIG3}) ? FDL_PARSE : FDL_DONE;
                    end
                end
                FDL_PARSE: begin
                    if (parse_cnt_ff == 7'h08) begin
                        state_ff <= (init_left_ff == 16'h0) ? FDL_DONE : FDL_INIT_LD;
                    end
                end
                FDL_INIT_LD: if (ld_cnt_ff == 6'h21) state_ff <= FDL_INIT_RUN;
                FDL_INIT_RUN: begin
                    if (init_done) begin
                        state_ff <= (init_left_ff == 16'h1) ? FDL_DONE : FDL_INIT_LD;
                    end
                end
                FDL_DONE: state_ff <= FDL_DONE;
                default: state_ff <= FDL_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fetch_ff <= 10'h0;
        end else if (state_ff == FDL_FETCH && rd_valid) begin
            fetch_ff <= fetch_ff + 10'h1;
        end
    end

    // read pointer and load counter; memory data arrives one cycle after the address
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_ptr_ff <= 10'h0;
            ld_cnt_ff <= 6'h0;
        end else begin
            case (state_ff)
                FDL_CHECK: begin
                    rd_ptr_ff <= (ld_cnt_ff < 6'h3) ? FDL_OFS_SIG + {4'h0, ld_cnt_ff} + 10'h1 :
                                 (ld_cnt_ff == 6'h3) ? FDL_OFS_ERASE :
                                 (ld_cnt_ff == 6'h4) ? FDL_OFS_ERASE + 10'h1 : FDL_OFS_FLAGS;
                    ld_cnt_ff <= (ld_cnt_ff == 6'h06) ? 6'h0 : ld_cnt_ff + 6'h1;
                end
                FDL_PARSE: begin
                    rd_ptr_ff <= sel_ofs;
                    ld_cnt_ff <= 6'h0;
                end
                FDL_INIT_LD: begin
                    // entry base = init array + index * 32, over command then payload
                    rd_ptr_ff <= FDL_OFS_INIT + {init_idx_ff[4:0], 5'h0} + {4'h0, ld_cnt_ff};
                    ld_cnt_ff <= (ld_cnt_ff == 6'h21) ? 6'h0 : ld_cnt_ff + 6'h1;
                end
                default: begin
                    rd_ptr_ff <= FDL_OFS_SIG;
                    ld_cnt_ff <= 6'h0;
                end
            endcase
        end
    end

    // signature and erase size gathered while checking; flags cleared then and loaded at parse count 0
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sig_ff <= 32'h0000_0000;
            flags_ff <= 8'h00;
            erase_size_ff <= FDL_DEF_ERASE;
        end else if (state_ff == FDL_CHECK && ld_cnt_ff != 6'h0) begin
            // signature is complete from count 5 on; a blank or foreign sector keeps the default size
            case (ld_cnt_ff)
                6'h1, 6'h2, 6'h3, 6'h4: sig_ff <= {sig_ff[23:0], mem_q};
                6'h5: if (sig_ff == {FDL_SIG0, FDL_SIG1, FDL_SIG2, FDL_SIG3}) erase_size_ff[7:0] <= mem_q;
                6'h6: begin
                    if (sig_ff == {FDL_SIG0, FDL_SIG1, FDL_SIG2, FDL_SIG3}) erase_size_ff[15:8] <= mem_q;
                    flags_ff <= 8'h00;
                end
                default: sig_ff <= sig_ff;
            endcase
        end else if (state_ff == FDL_PARSE) begin
            if (parse_cnt_ff == 7'h0) flags_ff <= mem_q;
        end
    end

    // parse the set's init index, length and switchover fields; a small sequencer over memory reads
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            parse_cnt_ff <= 7'h0;
            parse_ofs_ff <= 7'h0;
            init_idx_ff <= 16'h0;
            init_left_ff <= 16'h0;
            switch_idx_ff <= 16'h0;
        end else if (state_ff == FDL_PARSE) begin
            parse_cnt_ff <= parse_cnt_ff + 7'h1;
            parse_ofs_ff <= FDL_SET_INIT_IDX + parse_cnt_ff;
            // offset 0x40 is addressed in count 1 and its byte arrives two cycles later
            case (parse_cnt_ff)
                7'h3: init_idx_ff[7:0] <= mem_q;
                7'h4: init_idx_ff[15:8] <= mem_q;
                7'h5: init_left_ff[7:0] <= mem_q;
                7'h6: init_left_ff[15:8] <= mem_q;
                7'h7: switch_idx_ff[7:0] <= mem_q;
                7'h8: switch_idx_ff[15:8] <= mem_q;
                default: ;
            endcase
        end else if (state_ff == FDL_INIT_RUN && init_done) begin
            init_idx_ff <= init_idx_ff + 16'h1;
            init_left_ff <= init_left_ff - 16'h1;
        end else begin
            parse_cnt_ff <= 7'h0;
            parse_ofs_ff <= 7'h0;
        end
    end

    // write size read during fetch directly from the byte stream
    logic [15:0] wsize_raw_ff;
    logic [7:0] flags_raw_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wsize_raw_ff <= 16'h0;
            flags_raw_ff <= 8'h00;
        end else if (state_ff == FDL_FETCH && rd_valid) begin
            if (fetch_ff == FDL_OFS_WRITE) wsize_raw_ff[7:0] <= rd_data;
            if (fetch_ff == FDL_OFS_WRITE + 10'h1) wsize_raw_ff[15:8] <= rd_data;
            if (fetch_ff == FDL_OFS_FLAGS) flags_raw_ff <= rd_data;
        end
    end

    // init entry words: 16 command bytes then 16 payload bytes, little-endian words
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            init_cmd_ff <= 128'h0;
            init_payload_ff <= 128'h0;
        end else if (state_ff == FDL_INIT_LD && ld_cnt_ff >= 6'h2) begin
            // entry byte n shows at count n+2: one cycle address register, one cycle memory
            if (ld_cnt_ff <= 6'h11) init_cmd_ff <= {mem_q, init_cmd_ff[127:8]};
            else init_payload_ff <= {mem_q, init_payload_ff[127:8]};
        end
    end

    // committed settings: defaults until signature passes; access protocol also waits until switchover has executed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            desc_valid_ff <= 1'b0;
            access_prot_ff <= FDL_PROT_SINGLE;
            full_speed_ff <= 1'b0;
            init_high_clk_ff <= 1'b0;
            switched_ff <= 1'b0;
            image_start_ff <= FDL_IMAGE_START;
        end else begin
            image_start_ff <= FDL_IMAGE_START;
            if (state_ff == FDL_PARSE && parse_cnt_ff == 7'h1) begin
                desc_valid_ff <= 1'b1;
                full_speed_ff <= flags_raw_ff[FDL_FLAG_FULL_SPEED];
                init_high_clk_ff <= flags_raw_ff[FDL_FLAG_HIGH_CLK];
            end
            if (state_ff == FDL_INIT_RUN && init_done && init_idx_ff == switch_idx_ff) begin
                switched_ff <= 1'b1;
            end
            if (!desc_valid_ff) access_prot_ff <= FDL_PROT_SINGLE;
            else if (switched_ff) access_prot_ff <= cmd_word_ff[3:1];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            write_size_ff <= FDL_DEF_WRITE;
        end else if (state_ff == FDL_PARSE && parse_cnt_ff == 7'h1) begin
            write_size_ff <= wsize_raw_ff;
        end
    end

    // command word lookup: host selects slot, taken from the set of the current mode
    logic [127:0] cmd_shadow [4];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_word_ff <= 128'h0;
        end else if (desc_valid_ff) begin
            cmd_word_ff <= cmd_shadow[cmd_sel];
        end
    end
    // shadows loaded straight from the byte stream per mode-independent slot of both sets
    genvar gs;
    generate
        for (gs = 0; gs < 4; gs++) begin : g_slot
            logic [127:0] lo_ff;
            logic [127:0] hi_ff;
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    lo_ff <= 128'h0;
                    hi_ff <= 128'h0;
                end else if (state_ff == FDL_FETCH && rd_valid) begin
                    if (fetch_ff >= FDL_OFS_SET_LOW + 10'(gs * 16) && fetch_ff < FDL_OFS_SET_LOW + 10'(gs * 16 + 16))
                        lo_ff <= {rd_data, lo_ff[127:8]};
                    if (fetch_ff >= FDL_OFS_SET_HIGH + 10'(gs * 16) && fetch_ff < FDL_OFS_SET_HIGH + 10'(gs * 16 + 16))
                        hi_ff <= {rd_data, hi_ff[127:8]};
                end
            end
            assign cmd_shadow[gs] = high_clk_mode ? hi_ff : lo_ff;
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) load_done_ff <= 1'b0;
        else if (state_ff == FDL_DONE) load_done_ff <= 1'b1;
    end

    // flags_ff stays zero unless the signature passed
    assign boot_en = load_done_ff && !(flags_ff[FDL_FLAG_NO_BOOT] && desc_valid_ff && fatal_error);

    chk_boot_block: assert property (@(posedge clk) disable iff (rst)
        (desc_valid_ff && flags_raw_ff[FDL_FLAG_NO_BOOT] && fatal_error) |-> !boot_en) else $error("boot not blocked");
    chk_boot_free: assert property (@(posedge clk) disable iff (rst)
        (load_done_ff && !flags_raw_ff[FDL_FLAG_NO_BOOT]) |-> boot_en) else $error("boot blocked wrongly");
    chk_default_spi: assert property (@(posedge clk) disable iff (rst)
        !desc_valid_ff |=> access_prot_ff == FDL_PROT_SINGLE) else $error("non-default access without descriptor");
    chk_fetch_region: assert property (@(posedge clk) disable iff (rst)
        rd_req |-> rd_addr < FDL_DESC_REGION_BYTES) else $error("fetch outside descriptor region");
    chk_image_start: assert property (@(posedge clk) disable iff (rst)
        load_done_ff |-> image_start_ff == FDL_IMAGE_START) else $error("image start wrong");
    chk_sig_reject: assert property (@(posedge clk) disable iff (rst)
        (state_ff == FDL_CHECK && ld_cnt_ff == 6'h06 && sig_ff != 32'hA7F1_A5F1) |=> state_ff == FDL_DONE && !desc_valid_ff)
        else $error("bad signature accepted");
    chk_init_count: assert property (@(posedge clk) disable iff (rst)
        (state_ff == FDL_INIT_RUN && init_done && init_left_ff == 16'h1) |=> state_ff == FDL_DONE)
        else $error("init count wrong");
    chk_write_size: assert property (@(posedge clk) disable iff (rst)
        $rose(desc_valid_ff) |-> write_size_ff == wsize_raw_ff) else $error("write size not taken");
    cov_valid: cover property (@(posedge clk) $rose(desc_valid_ff));
    cov_done_default: cover property (@(posedge clk) $rose(load_done_ff) && !desc_valid_ff);
    cov_switch: cover property (@(posedge clk) $rose(switched_ff));
endmodule : fdl_loader

/* File: core/fdl_pkg.sv */
// package of offsets, field positions and counts for the flash descriptor loader
package fdl_pkg;
    localparam logic [23:0] FDL_DESC_REGION_BYTES = 24'h00_1000;
    localparam logic [23:0] FDL_IMAGE_START = 24'h00_1F84;
    localparam logic [9:0] FDL_OFS_SIG = 10'h000;
    localparam logic [9:0] FDL_OFS_ERASE = 10'h005;
    localparam logic [9:0] FDL_OFS_WRITE = 10'h007;
    localparam logic [9:0] FDL_OFS_SET_LOW = 10'h009;
    localparam logic [9:0] FDL_OFS_SET_HIGH = 10'h051;
    localparam logic [9:0] FDL_OFS_INIT = 10'h099;
    localparam logic [9:0] FDL_OFS_FLAGS = 10'h2D9;
    localparam logic [9:0] FDL_DESC_LAST = 10'h2D9;
    localparam logic [9:0] FDL_SET_BYTES = 10'h048;
    localparam logic [9:0] FDL_INIT_BYTES = 10'h020;
    localparam logic [6:0] FDL_SET_CHIP_ERASE = 7'h00;
    localparam logic [6:0] FDL_SET_SECT_ERASE = 7'h10;
    localparam logic [6:0] FDL_SET_READ = 7'h20;
    localparam logic [6:0] FDL_SET_WRITE = 7'h30;
    localparam logic [6:0] FDL_SET_INIT_IDX = 7'h40;
    localparam logic [6:0] FDL_SET_INIT_LEN = 7'h42;
    localparam logic [6:0] FDL_SET_SWITCH = 7'h44;
    localparam logic [4:0] FDL_INIT_ENTRIES = 5'h12;
    localparam logic [4:0] FDL_CMD_BYTES = 5'h10;
    localparam logic [7:0] FDL_SIG0 = 8'hA7;
    localparam logic [7:0] FDL_SIG1 = 8'hF1;
    localparam logic [7:0] FDL_SIG2 = 8'hA5;
    localparam logic [7:0] FDL_SIG3 = 8'hF1;
    localparam int FDL_FLAG_FULL_SPEED = 0;
    localparam int FDL_FLAG_HIGH_CLK = 1;
    localparam int FDL_FLAG_NO_BOOT = 2;
    localparam logic [2:0] FDL_PROT_SINGLE = 3'h1;
    localparam logic [15:0] FDL_DEF_ERASE = 16'h1000;
    localparam logic [15:0] FDL_DEF_WRITE = 16'h0100;
    typedef enum logic [1:0] {FDL_CMD_CHIP_ERASE, FDL_CMD_SECT_ERASE, FDL_CMD_READ, FDL_CMD_WRITE} fdl_cmd_t;
endpackage : fdl_pkg

/* File: core/fdl_desc_mem.sv */
// byte memory holding the descriptor copy, registered read port
`timescale 1ns/1ps
module fdl_desc_mem #(
    parameter int DEPTH = 1024,
    parameter int AW = 10
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data_ff
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        rd_data_ff <= mem[rd_addr];
    end
endmodule : fdl_desc_mem

/* File: sim/fdl_flash_model.sv */
// behavioural serial flash: serves sector-0 bytes and acknowledges init entries
`timescale 1ns/1ps
module fdl_flash_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic rd_req,
    input wire logic [23:0] rd_addr,
    output logic rd_valid,
    output logic [7:0] rd_data,
    input wire logic init_req,
    output logic init_done
);
    // only the descriptor sector is modelled; the bench fills it directly
    logic [7:0] mem [0:4095];
    logic [7:0] junk_ff;

    // data follows the address while valid, so back-to-back bytes never carry a stale value
    assign rd_data = rd_valid ? mem[rd_addr[11:0]] : junk_ff;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_valid <= 1'b0;
            init_done <= 1'b0;
            junk_ff <= 8'h5A;
        end else begin
            // pattern changes every cycle so an idle bus never looks like the last byte
            junk_ff <= junk_ff + 8'h3B;
            rd_valid <= rd_req && !stall;
            init_done <= init_req && !init_done && !stall;
        end
    end
endmodule : fdl_flash_model

/* File: sim/flash_descriptor_loader_bench.sv */
// self-checking bench for the flash descriptor loader against a reference model
`timescale 1ns/1ps
module flash_descriptor_loader_bench;
    import fdl_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic high_clk_mode = 1'b0;
    logic fatal_error = 1'b0;
    logic stall = 1'b0;
    logic slow = 1'b0;
    logic [1:0] cmd_sel = 2'h0;
    logic rd_req, rd_valid, init_req, init_done, desc_valid_ff, full_speed_ff;
    logic init_high_clk_ff, boot_en, load_done_ff;
    logic [2:0] access_prot_ff;
    logic [7:0] rd_data;
    logic [15:0] erase_size_ff, write_size_ff;
    logic [23:0] rd_addr, image_start_ff;
    logic [127:0] init_cmd_ff, init_payload_ff, cmd_word_ff;
    logic [31:0] seed = 32'h0000_001A;
    int fails = 0;
    int cmp_count = 0;
    int nxt = 0;
    int exp_q[$];

    always #2 clk = ~clk;

    fdl_loader u_dut (.clk(clk), .rst(rst), .start(start), .high_clk_mode(high_clk_mode),
        .fatal_error(fatal_error), .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid),
        .rd_data(rd_data), .init_req(init_req), .init_cmd_ff(init_cmd_ff),
        .init_payload_ff(init_payload_ff), .init_done(init_done), .cmd_sel(cmd_sel),
        .cmd_word_ff(cmd_word_ff), .desc_valid_ff(desc_valid_ff), .access_prot_ff(access_prot_ff),
        .full_speed_ff(full_speed_ff), .init_high_clk_ff(init_high_clk_ff),
        .erase_size_ff(erase_size_ff), .write_size_ff(write_size_ff),
        .image_start_ff(image_start_ff), .boot_en(boot_en), .load_done_ff(load_done_ff));

    fdl_flash_model u_flash (.clk(clk), .rst(rst), .stall(stall), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data), .init_req(init_req),
        .init_done(init_done));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [127:0] b16(input int a);
        logic [127:0] v;
        for (int i = 0; i < 16; i++) v[8*i +: 8] = u_flash.mem[a + i];
        return v;
    endfunction : b16

    task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %0h want %0h", $time, what, got, exp);
        end
    endtask : chk

    task automatic conclude();
        if (fails == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude

    always @(posedge clk) stall <= slow && (rnd() % 32'h0000_0003 != 32'h0000_0000);

    // every accepted byte address is checked for order and every executed init entry is compared with the model
    always @(posedge clk) begin
        if (!rst && rd_req && rd_valid) begin
            chk(rd_addr, 24'(nxt), "fetch address");
            nxt++;
        end
        if (!rst && init_req && init_done) begin
            if (exp_q.size() == 0) begin
                chk(1'b1, 1'b0, "extra init entry");
            end else begin
                chk(init_cmd_ff, b16(FDL_OFS_INIT + 32 * exp_q[0]), "init command");
                chk(init_payload_ff, b16(FDL_OFS_INIT + 32 * exp_q[0] + 16), "init payload");
                void'(exp_q.pop_front());
            end
        end
    end

    // kind 0: erased sector, 1: valid descriptor, 2: signature byte bad corrupted
    task automatic run(input int kind, input int bad);
        logic [31:0] r;
        logic [7:0] fl;
        logic vld;
        logic hcm;
        int base, idx, len;
        for (int i = 0; i < 4096; i++) begin
            r = rnd();
            u_flash.mem[i] = (kind == 0) ? 8'hFF : r[7:0];
        end
        r = rnd();
        idx = int'(r[15:0] % 16'h0012);
        len = int'(r[31:16] % 16'(19 - idx));
        r = rnd();
        hcm = r[0];
        vld = (kind == 1);
        if (kind != 0) begin
            u_flash.mem[0] = FDL_SIG0;
            u_flash.mem[1] = FDL_SIG1;
            u_flash.mem[2] = FDL_SIG2;
            u_flash.mem[3] = FDL_SIG3;
            if (kind == 2) u_flash.mem[bad] = u_flash.mem[bad] ^ 8'h10;
            // both sets get the same init fields so the set used during init does not matter
            for (int s = 0; s < 2; s++) begin
                base = s ? FDL_OFS_SET_HIGH : FDL_OFS_SET_LOW;
                u_flash.mem[base + FDL_SET_INIT_IDX] = 8'(idx);
                u_flash.mem[base + FDL_SET_INIT_IDX + 1] = 8'h00;
                u_flash.mem[base + FDL_SET_INIT_LEN] = 8'(len);
                u_flash.mem[base + FDL_SET_INIT_LEN + 1] = 8'h00;
                u_flash.mem[base + FDL_SET_SWITCH] = 8'(idx + len / 2);
                u_flash.mem[base + FDL_SET_SWITCH + 1] = 8'h00;
            end
            u_flash.mem[FDL_OFS_FLAGS][FDL_FLAG_HIGH_CLK] = hcm;
        end
        fl = u_flash.mem[FDL_OFS_FLAGS];
        base = hcm ? FDL_OFS_SET_HIGH : FDL_OFS_SET_LOW;
        exp_q.delete();
        if (vld) for (int e = idx; e < idx + len; e++) exp_q.push_back(e);
        @(posedge clk);
        rst <= 1'b1;
        high_clk_mode <= hcm;
        fatal_error <= 1'b0;
        repeat (16) @(posedge clk);
        nxt = 0;
        rst <= 1'b0;
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (int n = 0; n < 20000 && load_done_ff !== 1'b1; n++) @(posedge clk);
        #1 chk(load_done_ff, 1'b1, "load finished");
        chk(nxt, 32'h0000_02DA, "bytes fetched");
        chk(exp_q.size(), 0, "init entries run");
        chk(desc_valid_ff, vld, "descriptor valid");
        chk(image_start_ff, FDL_IMAGE_START, "image start");
        chk(erase_size_ff, vld ? {u_flash.mem[FDL_OFS_ERASE + 1], u_flash.mem[FDL_OFS_ERASE]} : FDL_DEF_ERASE,
            "erase size");
        chk(write_size_ff, vld ? {u_flash.mem[FDL_OFS_WRITE + 1], u_flash.mem[FDL_OFS_WRITE]} : FDL_DEF_WRITE,
            "write size");
        chk(full_speed_ff, vld & fl[FDL_FLAG_FULL_SPEED], "clock rate");
        chk(init_high_clk_ff, vld & hcm, "init clock mode");
        if (!vld) chk(access_prot_ff, FDL_PROT_SINGLE, "access protocol");
        if (vld) begin
            for (int s = 0; s < 4; s++) begin
                @(posedge clk);
                cmd_sel <= 2'(s);
                repeat (2) @(posedge clk);
                #1 chk(cmd_word_ff, b16(base + 16 * s), "command word");
            end
        end
        for (int f = 0; f < 2; f++) begin
            @(posedge clk);
            fatal_error <= f[0];
            @(posedge clk);
            #1 chk(boot_en, !(vld && fl[FDL_FLAG_NO_BOOT] && f[0]), "boot enable");
        end
        chk(access_prot_ff, (vld && len > 0) ? 3'(b16(base + 48) >> 1) : FDL_PROT_SINGLE, "switched protocol");
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk(rd_req, 1'b0, "restart ignored");
    endtask : run

    initial begin
        run(0, 0);
        for (int p = 0; p < 4; p++) run(2, p);
        for (int k = 0; k < 6; k++) begin
            slow = k[0];
            run(1, 0);
        end
        conclude();
    end

    // roughly six times the expected length of the eleven loads
    initial begin
        #360000;
        fails++;
        conclude();
    end
endmodule : flash_descriptor_loader_bench
